// ---- rtl/trig_in_pkg.sv ----
// Package: constants, register map and types of the trigger input conditioner
package trig_in_pkg;

  localparam int NUM_INPUTS          = 4;
  localparam int SEL_W               = 2;
  localparam int ADDR_W              = 8;
  localparam int DATA_W              = 32;

  // Timing: clock rate and stability step, times in picoseconds
  localparam int CLK_FREQ_MHZ        = 100;
  localparam int CLK_PERIOD_PS       = 1000000 / CLK_FREQ_MHZ;
  localparam int STABILITY_STEP_PS   = 9600;
  localparam int STABILITY_MAX_PS    = 604800;
  localparam int STABILITY_MAX_STEPS = STABILITY_MAX_PS / STABILITY_STEP_PS;
  localparam int STEPS_W             = 6;
  localparam int ELAPSED_W           = 20;

  // Decimation
  localparam int FACTOR_W            = 31;
  localparam int PHASE_W             = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_STABILITY  = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_LEVELS     = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_SELECT     = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_SENSE      = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_FACTOR     = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_PHASE      = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_MODE       = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_STATUS     = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_EDGE_COUNT = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_FWD_COUNT  = 8'h24;

  // Status register fields
  localparam int STATUS_ACTIVE_BIT   = 0;
  localparam int STATUS_RAW_BIT      = 1;

  typedef enum logic {
    sense_low,
    sense_high
  } trigger_input_sense_t;

  typedef enum logic [1:0] {
    mode_generator,
    mode_external,
    mode_software
  } trigger_source_mode_t;

  // Reset values and limits
  localparam logic [STEPS_W-1:0]  STABILITY_RST        = STEPS_W'(STABILITY_MAX_STEPS);
  localparam logic [STEPS_W-1:0]  STABILITY_MIN        = 6'h01;
  localparam logic [SEL_W-1:0]    SELECT_FRONT_INPUT_0 = 2'h0;
  localparam trigger_input_sense_t SENSE_RST           = sense_high;
  localparam trigger_source_mode_t MODE_RST            = mode_generator;
  localparam logic [FACTOR_W-1:0] FACTOR_RST           = 31'h00000001;
  localparam logic [FACTOR_W-1:0] FACTOR_MAX           = 31'h7FFFFFFF;
  localparam logic [PHASE_W-1:0]  PHASE_RST            = 32'h00000000;

endpackage

// ---- rtl/input_debouncer.sv ----
// Module: two-flop synchroniser and stability filter for one front input
`timescale 1ns/1ps
module input_debouncer
  import trig_in_pkg::*;
(
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // Raw pin and shared setting
  input  wire logic               raw_in,
  input  wire logic [STEPS_W-1:0] stability_steps,
  // Filtered level
  output logic                    level_out
);

  typedef struct packed {
    logic                 sync_a;
    logic                 sync_b;
    logic                 last;
    logic [ELAPSED_W-1:0] elapsed;
    logic                 level;
  } deb_state_t;

  deb_state_t           s_q;
  deb_state_t           s_d;
  logic [ELAPSED_W-1:0] threshold;
  logic [ELAPSED_W-1:0] elapsed_next;

  always_comb begin
    s_d          = s_q;
    threshold    = ELAPSED_W'(stability_steps * STABILITY_STEP_PS);
    elapsed_next = s_q.elapsed + ELAPSED_W'(CLK_PERIOD_PS);
    s_d.sync_a   = raw_in;
    s_d.sync_b   = s_q.sync_a;
    s_d.last     = s_q.sync_b;
    // Time is kept in picoseconds so the 9.6 ns step rounds up to whole cycles
    if (s_q.sync_b != s_q.last) begin
      s_d.elapsed = '0;
    end else if (s_q.elapsed < threshold) begin
      s_d.elapsed = elapsed_next;
    end
    if (s_q.sync_b == s_q.last && elapsed_next >= threshold) begin
      s_d.level = s_q.last;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level_out = s_q.level;

endmodule

// ---- rtl/pulse_decimator.sv ----
// Module: passes one pulse of each group of N, at a programmable phase
`timescale 1ns/1ps
module pulse_decimator
  import trig_in_pkg::*;
(
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // Pulses in and settings
  input  wire logic                pulse_in,
  input  wire logic [FACTOR_W-1:0] factor,
  input  wire logic [PHASE_W-1:0]  phase,
  // Surviving pulses
  output logic                     pulse_out
);

  typedef struct packed {
    logic [FACTOR_W-1:0] pos;
    logic                out;
  } dec_state_t;

  dec_state_t          s_q;
  dec_state_t          s_d;
  logic [FACTOR_W-1:0] pos_eff;

  always_comb begin
    s_d     = s_q;
    s_d.out = 1'b0;
    // A factor lowered below the position restarts the group
    pos_eff = (s_q.pos >= factor) ? '0 : s_q.pos;
    s_d.pos = pos_eff;
    if (pulse_in) begin
      // A phase not below the factor never matches, so nothing passes
      s_d.out = ({1'b0, pos_eff} == phase);
      s_d.pos = (pos_eff >= factor - 1'b1) ? '0 : pos_eff + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pulse_out = s_q.out;

endmodule

// ---- rtl/trigger_input_conditioner.sv ----
// Module: front trigger input conditioner with APB register slave
`timescale 1ns/1ps
module trigger_input_conditioner
  import trig_in_pkg::*;
(
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,

  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic [DATA_W-1:0]     pwdata,
  output logic      [DATA_W-1:0]     prdata,
  output logic                       pready,
  output logic                       pslverr,

  // Front inputs from the pins
  input  wire logic [NUM_INPUTS-1:0] front_in,

  // Toward the trigger system
  output logic                       trigger_pulse,
  output logic                       stat_level,
  output logic                       stat_pulse
);

  typedef struct packed {
    logic                 pready;
    logic                 pslverr;
    logic [DATA_W-1:0]    prdata;
    logic [STEPS_W-1:0]   stability;
    logic [SEL_W-1:0]     select;
    trigger_input_sense_t sense;
    trigger_source_mode_t mode;
    logic [FACTOR_W-1:0]  factor;
    logic [PHASE_W-1:0]   phase;
    logic                 active_prev;
    logic                 stat_level;
    logic                 stat_pulse;
    logic                 ext_pulse;
    logic [DATA_W-1:0]    edge_count;
    logic [DATA_W-1:0]    fwd_count;
  } regs_t;

  localparam regs_t REGS_RST = '{
    pready:      1'b0,
    pslverr:     1'b0,
    prdata:      '0,
    stability:   STABILITY_RST,
    select:      SELECT_FRONT_INPUT_0,
    sense:       SENSE_RST,
    mode:        MODE_RST,
    factor:      FACTOR_RST,
    phase:       PHASE_RST,
    active_prev: 1'b0,
    stat_level:  1'b0,
    stat_pulse:  1'b0,
    ext_pulse:   1'b0,
    edge_count:  '0,
    fwd_count:   '0
  };

  regs_t                 r_q;
  regs_t                 r_d;

  logic [NUM_INPUTS-1:0] levels;
  logic                  fwd_pulse;
  logic                  selected_level;
  logic                  active_level;
  logic                  rising;
  logic                  access;
  logic                  wr_done;
  logic [ADDR_W-1:0]     word_addr;
  logic                  mapped;
  logic [DATA_W-1:0]     rd_value;

  // One debouncer per input, all sharing the same stability setting
  for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_deb
    input_debouncer u_deb (
      .pclk            (pclk),
      .presetn         (presetn),
      .raw_in          (front_in[i]),
      .stability_steps (r_q.stability),
      .level_out       (levels[i])
    );
  end

  pulse_decimator u_dec (
    .pclk      (pclk),
    .presetn   (presetn),
    .pulse_in  (r_q.ext_pulse),
    .factor    (r_q.factor),
    .phase     (r_q.phase),
    .pulse_out (fwd_pulse)
  );

  // Selection and sense
  always_comb begin
    selected_level = levels[r_q.select];
    active_level   = (r_q.sense == sense_high) ? selected_level
                                               : ~selected_level;
    rising         = active_level & ~r_q.active_prev;
  end

  // Bus decode
  always_comb begin
    access    = psel & penable;
    wr_done   = access & r_q.pready & pwrite & ~r_q.pslverr;
    word_addr = {paddr[ADDR_W-1:2], 2'b00};
    mapped    = 1'b1;
    rd_value  = '0;
    unique case (word_addr)
      OFF_STABILITY: begin
        rd_value[STEPS_W-1:0] = r_q.stability;
      end
      OFF_LEVELS: begin
        rd_value[NUM_INPUTS-1:0] = levels;
      end
      OFF_SELECT: begin
        rd_value[SEL_W-1:0] = r_q.select;
      end
      OFF_SENSE: begin
        rd_value[0] = r_q.sense;
      end
      OFF_FACTOR: begin
        rd_value[FACTOR_W-1:0] = r_q.factor;
      end
      OFF_PHASE: begin
        rd_value = r_q.phase;
      end
      OFF_MODE: begin
        rd_value[1:0] = r_q.mode;
      end
      OFF_STATUS: begin
        rd_value[STATUS_ACTIVE_BIT] = active_level;
        rd_value[STATUS_RAW_BIT]    = selected_level;
      end
      OFF_EDGE_COUNT: begin
        rd_value = r_q.edge_count;
      end
      OFF_FWD_COUNT: begin
        rd_value = r_q.fwd_count;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Next state
  always_comb begin
    r_d = r_q;

    // APB answers one cycle into the access phase, data from a register
    r_d.pready  = 1'b0;
    r_d.pslverr = 1'b0;
    if (access && !r_q.pready) begin
      r_d.pready  = 1'b1;
      r_d.pslverr = ~mapped;
      r_d.prdata  = (pwrite || !mapped) ? '0 : rd_value;
    end

    // Writes land on the edge where pready is seen high
    if (wr_done) begin
      unique case (word_addr)
        OFF_STABILITY: begin
          if (pwdata[DATA_W-1:STEPS_W] != '0) begin
            r_d.stability = STABILITY_RST;
          end else if (pwdata[STEPS_W-1:0] == '0) begin
            r_d.stability = STABILITY_MIN;
          end else begin
            r_d.stability = pwdata[STEPS_W-1:0];
          end
        end
        OFF_SELECT: begin
          r_d.select = pwdata[SEL_W-1:0];
        end
        OFF_SENSE: begin
          r_d.sense = trigger_input_sense_t'(pwdata[0]);
        end
        OFF_FACTOR: begin
          if (pwdata[DATA_W-1]) begin
            r_d.factor = FACTOR_MAX;
          end else if (pwdata[FACTOR_W-1:0] == '0) begin
            r_d.factor = FACTOR_RST;
          end else begin
            r_d.factor = pwdata[FACTOR_W-1:0];
          end
        end
        OFF_PHASE: begin
          r_d.phase = pwdata;
        end
        OFF_MODE: begin
          // The unused mode code is ignored rather than stored
          if (pwdata[DATA_W-1:2] == '0 && pwdata[1:0] != 2'h3) begin
            r_d.mode = trigger_source_mode_t'(pwdata[1:0]);
          end
        end
        default: begin
          // Read-only words ignore writes
        end
      endcase
    end

    // Statistics tap: after filtering and sense, ahead of decimation
    r_d.active_prev = active_level;
    r_d.stat_level  = active_level;
    r_d.stat_pulse  = rising;
    if (rising) begin
      r_d.edge_count = r_q.edge_count + 1'b1;
    end

    // Only external mode lets the selected input drive triggers
    r_d.ext_pulse = rising & (r_q.mode == mode_external);

    // Counters wrap to zero at their maximum
    if (fwd_pulse) begin
      r_d.fwd_count = r_q.fwd_count + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= REGS_RST;
    end else begin
      r_q <= r_d;
    end
  end

  // Outputs
  assign prdata        = r_q.prdata;
  assign pready        = r_q.pready;
  assign pslverr       = r_q.pslverr;
  assign trigger_pulse = fwd_pulse;
  assign stat_level    = r_q.stat_level;
  assign stat_pulse    = r_q.stat_pulse;

endmodule

// ---- verif/front_source.sv ----
// Model of the external trigger sources wired to the front pins
`timescale 1ns/1ps
module front_source (
  // Steady levels and spikes requested by the bench
  input  wire logic [3:0] lvl,
  input  wire logic [3:0] glitch,
  // Front pins
  output logic      [3:0] front_in
);
  // A spike flips the line for a few cycles, as a bouncing cable would
  assign front_in = lvl ^ glitch;
endmodule

// ---- verif/trigger_input_conditioner_assertions.sv ----
// Checker of the port behaviour of the trigger input conditioner
`timescale 1ns/1ps
module trigger_input_conditioner_assertions
  import trig_in_pkg::*;
(
  // Clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // APB
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [ADDR_W-1:0]     paddr,
  input wire logic [DATA_W-1:0]     pwdata,
  input wire logic [DATA_W-1:0]     prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // Pins and trigger side
  input wire logic [NUM_INPUTS-1:0] front_in,
  input wire logic                  trigger_pulse,
  input wire logic                  stat_level,
  input wire logic                  stat_pulse
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_READY_ONE: assert property (
    psel && penable && !pready |=> pready) else $error("pready late");
  AST_READY_SINGLE: assert property (
    pready |=> !pready) else $error("pready held");
  AST_ERR_WITH_READY: assert property (
    pslverr |-> pready && prdata == '0) else $error("bad error answer");
  AST_TRIG_SINGLE: assert property (
    trigger_pulse |=> !trigger_pulse) else $error("trigger pulse long");
  AST_STAT_SINGLE: assert property (
    stat_pulse |=> !stat_pulse) else $error("stat pulse long");
  AST_STAT_ON_LEVEL: assert property (
    stat_pulse |-> stat_level) else $error("stat pulse on idle level");
  AST_TRIG_FROM_STAT: assert property (
    trigger_pulse |-> $past(stat_pulse)) else $error("trigger without edge");
  AST_RISE_GIVES_PULSE: assert property (
    $rose(stat_level) |-> ##[0:1] stat_pulse) else $error("active edge lost");
endmodule

// ---- verif/test_trigger_input_conditioner.sv ----
// Self-checking testbench of the trigger input conditioner
`timescale 1ns/1ps
module test_trigger_input_conditioner
  import trig_in_pkg::*;
;
  logic                  pclk, presetn, psel, penable, pwrite;
  logic [ADDR_W-1:0]     paddr;
  logic [DATA_W-1:0]     pwdata, prdata, rd;
  logic                  pready, pslverr, err, trigger_pulse, stat_level, stat_pulse;
  logic [NUM_INPUTS-1:0] front_in, lvl, glitch;
  int                    num_errors, tests_run, sc, tc, fi, s0, t0, n, k;
  logic [ADDR_W-1:0]     ra [6] = '{OFF_STABILITY, OFF_SELECT, OFF_SENSE, OFF_FACTOR,
                                    OFF_PHASE, OFF_MODE};
  logic [DATA_W-1:0]     rv [6] = '{32'h3F, 32'h0, 32'h1, 32'h1, 32'h0, 32'h0};
  int                    st [3] = '{1, 20, 63};

  trigger_input_conditioner dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .front_in, .trigger_pulse, .stat_level,
    .stat_pulse);
  front_source src_u (.lvl, .glitch, .front_in);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Pulse counters; fi keeps the edge count seen at the latest trigger
  always @(posedge pclk) begin
    if (stat_pulse) sc <= sc + 1;
    if (trigger_pulse) begin
      tc <= tc + 1;
      fi <= sc;
    end
  end

  task results();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits for pready under a bound
  task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int m;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    m = 0;
    do begin
      @(posedge pclk);
      m++;
    end while (pready !== 1'b1 && m < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (m >= 50) begin
      num_errors++;
      results();
    end
  endtask

  task pulse(input int i, input int w);
    @(posedge pclk);
    lvl[i] <= ~lvl[i];
    repeat (w) @(posedge pclk);
    lvl[i] <= ~lvl[i];
    repeat (w) @(posedge pclk);
  endtask

  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    {paddr, pwdata, lvl, glitch} = '0;
    {sc, tc, fi, num_errors, tests_run} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, rv[i]);
    end
    apb(1'b1, OFF_LEVELS, 32'hF);
    apb(1'b0, OFF_LEVELS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, OFF_FACTOR, 32'hFFFFFFFF);
    apb(1'b0, OFF_FACTOR, 32'h0);
    chk(rd, 32'h7FFFFFFF);
    $display("test registers done");
    // Latency has to scale with the step count, so three settings are measured
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, OFF_STABILITY, st[i]);
      k = (st[i] * 96 + 99) / 100;
      @(posedge pclk);
      lvl[0] <= 1'b1;
      n = 0;
      while (stat_pulse !== 1'b1 && n < 100) begin
        @(posedge pclk);
        n++;
      end
      chk(n >= k + 2 && n <= k + 7, 1'b1);
      lvl[0] <= 1'b0;
      repeat (k + 10) @(posedge pclk);
    end
    apb(1'b1, OFF_STABILITY, 32'd20);
    s0 = sc;
    @(posedge pclk);
    glitch[0] <= 1'b1;
    repeat (10) @(posedge pclk);
    glitch[0] <= 1'b0;
    repeat (60) @(posedge pclk);
    chk(sc - s0, 0);
    lvl <= 4'hF;
    apb(1'b0, OFF_LEVELS, 32'h0);
    chk(rd, 32'h0);
    repeat (30) @(posedge pclk);
    apb(1'b0, OFF_LEVELS, 32'h0);
    chk(rd, 32'hF);
    lvl <= 4'hA;
    repeat (30) @(posedge pclk);
    apb(1'b0, OFF_LEVELS, 32'h0);
    chk(rd, 32'hA);
    lvl <= 4'h0;
    $display("test debounce done");
    apb(1'b1, OFF_SELECT, 32'h2);
    apb(1'b1, OFF_SENSE, 32'h0);
    repeat (30) @(posedge pclk);
    chk(stat_level, 1'b1);
    lvl[0] <= 1'b1;
    repeat (30) @(posedge pclk);
    chk(stat_level, 1'b1);
    lvl[2] <= 1'b1;
    repeat (30) @(posedge pclk);
    chk(stat_level, 1'b0);
    lvl <= 4'h0;
    apb(1'b1, OFF_SENSE, 32'h1);
    apb(1'b1, OFF_SELECT, 32'h0);
    repeat (30) @(posedge pclk);
    $display("test select done");
    apb(1'b1, OFF_STABILITY, 32'h1);
    apb(1'b1, OFF_MODE, 32'h1);
    apb(1'b1, OFF_FACTOR, 32'h3);
    apb(1'b1, OFF_PHASE, 32'h1);
    {s0, t0} = {sc, tc};
    repeat (6) pulse(0, 8);
    chk(tc - t0, 2);
    chk(fi - s0, 5);
    chk(sc - s0, 6);
    apb(1'b1, OFF_FACTOR, 32'h1);
    apb(1'b1, OFF_PHASE, 32'h0);
    t0 = tc;
    repeat (3) pulse(0, 8);
    chk(tc - t0, 3);
    for (int m = 0; m < 3; m += 2) begin
      apb(1'b1, OFF_MODE, m);
      {s0, t0} = {sc, tc};
      repeat (3) pulse(0, 8);
      chk(tc - t0, 0);
      chk(sc - s0, 3);
    end
    apb(1'b0, OFF_FWD_COUNT, 32'h0);
    chk(rd, 32'h5);
    $display("test decimation done");
    results();
  end
endmodule

bind trigger_input_conditioner trigger_input_conditioner_assertions chk_u (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .front_in,
  .trigger_pulse, .stat_level, .stat_pulse);
